//--- shared/tpc_pkg.sv
// Package with register map, field layout and prescaler constants for the timer clock block
package tpc_pkg;

  // Bus widths
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;

  // Register offsets
  localparam logic [7:0]  OFS_GEN_SYNC   = 8'h23;  // general_timer_sync_control
  localparam logic [7:0]  OFS_SEL_T0     = 8'h30;  // Timer 0 clock_source_select
  localparam logic [7:0]  OFS_SEL_T1     = 8'h31;  // Timer 1 clock_source_select
  localparam logic [7:0]  OFS_PRESC_LO   = 8'h32;  // Prescaler count bits 7:0
  localparam logic [7:0]  OFS_PRESC_HI   = 8'h33;  // Prescaler count bits 9:8

  // Field positions in the general control register
  localparam int          BIT_SYNC_HOLD  = 7;
  localparam int          BIT_ASYNC_CLR  = 1;
  localparam int          BIT_SHARED_CLR = 0;

  // Reset values and unmapped answer
  localparam logic [7:0]  GEN_SYNC_RST   = 8'h00;
  localparam logic [2:0]  SEL_RST        = 3'h0;
  localparam logic [7:0]  RDATA_NONE     = 8'h00;

  // Clock source select encodings
  localparam int          SEL_W          = 3;
  localparam logic [2:0]  SEL_STOP       = 3'h0;
  localparam logic [2:0]  SEL_DIV1       = 3'h1;
  localparam logic [2:0]  SEL_DIV8       = 3'h2;
  localparam logic [2:0]  SEL_DIV64      = 3'h3;
  localparam logic [2:0]  SEL_DIV256     = 3'h4;
  localparam logic [2:0]  SEL_DIV1024    = 3'h5;
  localparam logic [2:0]  SEL_EXT_FALL   = 3'h6;
  localparam logic [2:0]  SEL_EXT_RISE   = 3'h7;

  // Prescaler width and terminal masks for each tap
  localparam int          PRESC_W        = 10;
  localparam logic [9:0]  PRESC_ZERO     = 10'h000;
  localparam logic [9:0]  PRESC_ONE      = 10'h001;
  localparam logic [9:0]  MASK_DIV8      = 10'h007;
  localparam logic [9:0]  MASK_DIV64     = 10'h03F;
  localparam logic [9:0]  MASK_DIV256    = 10'h0FF;
  localparam logic [9:0]  MASK_DIV1024   = 10'h3FF;

endpackage : tpc_pkg

//--- rtl/tpc_ext_edge.sv
// Pin synchroniser and edge detector for one external timer clock pin
`timescale 1ns/100ps
module tpc_ext_edge (
  input  wire logic i_sys_clk,  // System clock
  input  wire logic i_sys_rst,  // Synchronous reset, active high
  input  wire logic i_pin,      // Raw external clock pin
  output logic      o_rise,     // One cycle: rising edge seen
  output logic      o_fall      // One cycle: falling edge seen
);

  logic latch_lvl;              // Transparent while clock high
  logic sync_q;                 // First registered sample
  logic sync_d;
  logic prev_q;                 // Sample one cycle older
  logic prev_d;

  // Front latch follows the pin in the clock-high phase; sync_q reads it, and prev_q too during reset
  always_latch begin
    if (i_sys_clk) begin
      latch_lvl = i_pin;
    end
  end

  // Next values of the sampling stages, one sample every cycle
  always_comb begin
    sync_d = latch_lvl;
    prev_d = sync_q;
    if (i_sys_rst) begin
      // Both stages take the pin level, so an idle-high pin gives no false edge
      sync_d = latch_lvl;
      prev_d = latch_lvl;
    end
  end

  // Sampling registers on the rising clock edge
  always_ff @(posedge i_sys_clk) begin
    sync_q <= sync_d;
    prev_q <= prev_d;
  end

  // Edges are judged on the two settled stages, never on the latch
  assign o_rise = sync_q & ~prev_q;
  assign o_fall = ~sync_q & prev_q;

endmodule : tpc_ext_edge

//--- rtl/tpc_top.sv
// Shared prescaler and clock source selection for two timers
`timescale 1ns/100ps
module tpc_top (
  input  wire logic       i_sys_clk,                 // System I/O clock, 40 MHz
  input  wire logic       i_sys_rst,                 // Synchronous reset, active high
  input  wire logic [7:0] i_addr,                    // Register address
  input  wire logic [7:0] i_wdata,                   // Register write data
  input  wire logic       i_wr,                      // Write strobe, one cycle
  input  wire logic       i_rd,                      // Read strobe, one cycle
  output logic      [7:0] o_rdata,                   // Read data, cycle after strobe
  input  wire logic       i_timer0_ext_clock_pin,    // External clock pin, timer 0
  input  wire logic       i_timer1_ext_clock_pin,    // External clock pin, timer 1
  output logic            o_timer0_count_clock,      // Count pulse to timer 0
  output logic            o_timer1_count_clock,      // Count pulse to timer 1
  output logic            o_shared_prescaler_reset,  // Shared prescaler held in reset
  output logic            o_async_prescaler_reset    // Request to the separate prescaler
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------

  // Control register fields
  logic       sync_hold_q;        // timer_sync_hold
  logic       sync_hold_d;
  logic       shared_clr_q;       // shared_prescaler_clear
  logic       shared_clr_d;
  logic       async_clr_q;        // async_prescaler_clear
  logic       async_clr_d;

  // Per-timer clock source selects
  logic [2:0] sel0_q;             // Timer 0 clock_source_select
  logic [2:0] sel0_d;
  logic [2:0] sel1_q;             // Timer 1 clock_source_select
  logic [2:0] sel1_d;

  // Read path
  logic [7:0] rdata_q;            // Registered read answer
  logic [7:0] rdata_d;

  // Shared prescaler
  logic [9:0] presc_q;            // Free-running division count
  logic [9:0] presc_d;
  logic       tap8;               // Terminal count of each tap
  logic       tap64;
  logic       tap256;
  logic       tap1024;

  // External pin edges, already synchronised
  logic       t0_rise;
  logic       t0_fall;
  logic       t1_rise;
  logic       t1_fall;

  // Count pulses
  logic       cnt0_q;             // timer0_count_clock
  logic       cnt0_d;
  logic       cnt1_q;             // timer1_count_clock
  logic       cnt1_d;

  // Write decode
  logic       wr_gen;             // Write to control register
  logic       wr_sel0;
  logic       wr_sel1;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------

  // True when the count has all bits of a tap mask set
  function automatic logic tap_end(input logic [9:0] cnt,
                                   input logic [9:0] mask);
    tap_end = ((cnt & mask) == mask);
  endfunction : tap_end

  // Pick one timer's count pulse from its select; used for both timers
  function automatic logic pick_clock(input logic [2:0] sel,
                                      input logic       t_8,
                                      input logic       t_64,
                                      input logic       t_256,
                                      input logic       t_1024,
                                      input logic       rise,
                                      input logic       fall);
    case (sel)
      tpc_pkg::SEL_STOP:     pick_clock = 1'b0;
      tpc_pkg::SEL_DIV1:     pick_clock = 1'b1;
      tpc_pkg::SEL_DIV8:     pick_clock = t_8;
      tpc_pkg::SEL_DIV64:    pick_clock = t_64;
      tpc_pkg::SEL_DIV256:   pick_clock = t_256;
      tpc_pkg::SEL_DIV1024:  pick_clock = t_1024;
      tpc_pkg::SEL_EXT_FALL: pick_clock = fall;
      tpc_pkg::SEL_EXT_RISE: pick_clock = rise;
      default:               pick_clock = 1'b0;
    endcase
  endfunction : pick_clock

  // ---------------------------------------------------------------
  // Register write decode
  // ---------------------------------------------------------------

  // A strobe with a matching address selects one register
  always_comb begin
    wr_gen  = i_wr && (i_addr == tpc_pkg::OFS_GEN_SYNC);
    wr_sel0 = i_wr && (i_addr == tpc_pkg::OFS_SEL_T0);
    wr_sel1 = i_wr && (i_addr == tpc_pkg::OFS_SEL_T1);
  end

  // ---------------------------------------------------------------
  // General control register
  // ---------------------------------------------------------------

  // Next value of hold and clear bits. A clear bit is kept only while
  // hold is set; otherwise it lives for a single cycle, which is just
  // enough to reset the prescaler. Reserved bits are not stored.
  always_comb begin
    sync_hold_d  = sync_hold_q;
    shared_clr_d = shared_clr_q;
    async_clr_d  = async_clr_q;
    if (!sync_hold_q) begin
      // Self-clearing, and hold just written to zero clears both
      shared_clr_d = 1'b0;
      async_clr_d  = 1'b0;
    end
    if (wr_gen) begin
      // A fresh write wins over the hardware clear
      sync_hold_d  = i_wdata[tpc_pkg::BIT_SYNC_HOLD];
      shared_clr_d = i_wdata[tpc_pkg::BIT_SHARED_CLR];
      async_clr_d  = i_wdata[tpc_pkg::BIT_ASYNC_CLR];
    end
    if (i_sys_rst) begin
      sync_hold_d  = tpc_pkg::GEN_SYNC_RST[tpc_pkg::BIT_SYNC_HOLD];
      shared_clr_d = tpc_pkg::GEN_SYNC_RST[tpc_pkg::BIT_SHARED_CLR];
      async_clr_d  = tpc_pkg::GEN_SYNC_RST[tpc_pkg::BIT_ASYNC_CLR];
    end
  end

  // Control register storage
  always_ff @(posedge i_sys_clk) begin
    sync_hold_q  <= sync_hold_d;
    shared_clr_q <= shared_clr_d;
    async_clr_q  <= async_clr_d;
  end

  // ---------------------------------------------------------------
  // Clock source select registers
  // ---------------------------------------------------------------

  // Each timer keeps its own select; both feed from one prescaler
  always_comb begin
    sel0_d = sel0_q;
    sel1_d = sel1_q;
    if (wr_sel0) begin
      sel0_d = i_wdata[2:0];
    end
    if (wr_sel1) begin
      sel1_d = i_wdata[2:0];
    end
    if (i_sys_rst) begin
      sel0_d = tpc_pkg::SEL_RST;
      sel1_d = tpc_pkg::SEL_RST;
    end
  end

  // Select storage
  always_ff @(posedge i_sys_clk) begin
    sel0_q <= sel0_d;
    sel1_q <= sel1_d;
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------

  // Read answer is formed from the current state and stands in the
  // next cycle only; unmapped addresses answer zero
  always_comb begin
    rdata_d = tpc_pkg::RDATA_NONE;
    if (i_rd) begin
      case (i_addr)
        tpc_pkg::OFS_GEN_SYNC: begin
          // Bits six to two are reserved and read as zero
          rdata_d                         = 8'h00;
          rdata_d[tpc_pkg::BIT_SYNC_HOLD]  = sync_hold_q;
          rdata_d[tpc_pkg::BIT_ASYNC_CLR]  = async_clr_q;
          rdata_d[tpc_pkg::BIT_SHARED_CLR] = shared_clr_q;
        end
        tpc_pkg::OFS_SEL_T0: begin
          rdata_d = {5'h00, sel0_q};
        end
        tpc_pkg::OFS_SEL_T1: begin
          rdata_d = {5'h00, sel1_q};
        end
        tpc_pkg::OFS_PRESC_LO: begin
          // Live prescaler phase, handy for aligning software
          rdata_d = presc_q[7:0];
        end
        tpc_pkg::OFS_PRESC_HI: begin
          rdata_d = {6'h00, presc_q[9:8]};
        end
        default: begin
          rdata_d = tpc_pkg::RDATA_NONE;
        end
      endcase
    end
    if (i_sys_rst) begin
      rdata_d = tpc_pkg::RDATA_NONE;
    end
  end

  // Read data register; drops back to zero after its one cycle
  always_ff @(posedge i_sys_clk) begin
    rdata_q <= rdata_d;
  end

  // ---------------------------------------------------------------
  // Shared prescaler
  // ---------------------------------------------------------------

  // The counter runs every cycle whatever the selects say, so a timer
  // started on a tap sees a first pulse anywhere from 1 to N cycles
  // later. Reset forces zero, and zero is held while the clear stands.
  always_comb begin
    presc_d = presc_q + tpc_pkg::PRESC_ONE;
    if (shared_clr_q) begin
      presc_d = tpc_pkg::PRESC_ZERO;
    end
    if (i_sys_rst) begin
      presc_d = tpc_pkg::PRESC_ZERO;
    end
  end

  // Prescaler count storage
  always_ff @(posedge i_sys_clk) begin
    presc_q <= presc_d;
  end

  // Tap pulses at the last count of each period; held off during the
  // clear so that each tap's next full period starts at release
  always_comb begin
    tap8    = !shared_clr_q && tap_end(presc_q, tpc_pkg::MASK_DIV8);
    tap64   = !shared_clr_q && tap_end(presc_q, tpc_pkg::MASK_DIV64);
    tap256  = !shared_clr_q && tap_end(presc_q, tpc_pkg::MASK_DIV256);
    tap1024 = !shared_clr_q && tap_end(presc_q, tpc_pkg::MASK_DIV1024);
  end

  // ---------------------------------------------------------------
  // External pin synchronisers
  // ---------------------------------------------------------------

  // Pins are sampled whatever their port direction; the detectors run
  // all the time so a select change only gates already settled edges
  tpc_ext_edge u_edge_t0 (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_timer0_ext_clock_pin),
    .o_rise    (t0_rise),
    .o_fall    (t0_fall)
  );

  tpc_ext_edge u_edge_t1 (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_timer1_ext_clock_pin),
    .o_rise    (t1_rise),
    .o_fall    (t1_fall)
  );

  // ---------------------------------------------------------------
  // Count pulse selection
  // ---------------------------------------------------------------

  // One register stage after the edge detector gives the fixed pin to
  // count latency; pin pulses skip the prescaler entirely. Limitation:
  // changing a select to a pin mode while the pin moves may count once.
  always_comb begin
    cnt0_d = pick_clock(sel0_q, tap8, tap64, tap256, tap1024,
                        t0_rise, t0_fall);
    cnt1_d = pick_clock(sel1_q, tap8, tap64, tap256, tap1024,
                        t1_rise, t1_fall);
    if (i_sys_rst) begin
      cnt0_d = 1'b0;
      cnt1_d = 1'b0;
    end
  end

  // Count pulse registers
  always_ff @(posedge i_sys_clk) begin
    cnt0_q <= cnt0_d;
    cnt1_q <= cnt1_d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // All outputs come straight from flip-flops
  assign o_rdata                  = rdata_q;
  assign o_timer0_count_clock     = cnt0_q;
  assign o_timer1_count_clock     = cnt1_q;
  assign o_shared_prescaler_reset = shared_clr_q;
  assign o_async_prescaler_reset  = async_clr_q;

endmodule : tpc_top

//--- tb/tpc_top_asserts.sv
// Checker for the timer clock block, bound to its top module
`timescale 1ns/100ps
module tpc_top_asserts (
  input wire logic       i_sys_clk,                 // System clock
  input wire logic       i_sys_rst,                 // Reset, active high
  input wire logic [7:0] i_addr,                    // Register address
  input wire logic [7:0] i_wdata,                   // Write data
  input wire logic       i_wr,                      // Write strobe
  input wire logic       i_rd,                      // Read strobe
  input wire logic [7:0] o_rdata,                   // Read data
  input wire logic       i_timer0_ext_clock_pin,    // Pin of timer 0
  input wire logic       i_timer1_ext_clock_pin,    // Pin of timer 1
  input wire logic       o_timer0_count_clock,      // Count pulse, timer 0
  input wire logic       o_timer1_count_clock,      // Count pulse, timer 1
  input wire logic       o_shared_prescaler_reset,  // Shared clear level
  input wire logic       o_async_prescaler_reset    // Async clear level
);
  wire        t0 = o_timer0_count_clock;     // Short aliases
  wire        t1 = o_timer1_count_clock;
  wire        rs = o_shared_prescaler_reset;
  wire        p0 = i_timer0_ext_clock_pin;
  wire        p1 = i_timer1_ext_clock_pin;
  wire        wr_ctl = i_wr && (i_addr == tpc_pkg::OFS_GEN_SYNC);
  wire        rd_ctl = i_rd && (i_addr == tpc_pkg::OFS_GEN_SYNC);
  // Writes that may move the tap phase or stop timer 0
  wire        wr_cfg = wr_ctl || (i_wr && (i_addr == tpc_pkg::OFS_SEL_T0));
  logic       hold_q;                        // Hold bit as last written
  logic [2:0] sel0_q;                        // Timer 0 select as written
  logic [2:0] sel1_q;                        // Timer 1 select as written
  wire        both8 = (sel0_q == tpc_pkg::SEL_DIV8) && (sel1_q == tpc_pkg::SEL_DIV8);
  // Shadow of the settings, so outputs can be tied to what software asked
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      hold_q <= 1'b0;
      sel0_q <= tpc_pkg::SEL_RST;
      sel1_q <= tpc_pkg::SEL_RST;
    end else if (i_wr) begin
      if (i_addr == tpc_pkg::OFS_GEN_SYNC) hold_q <= i_wdata[7];
      if (i_addr == tpc_pkg::OFS_SEL_T0) sel0_q <= i_wdata[2:0];
      if (i_addr == tpc_pkg::OFS_SEL_T1) sel1_q <= i_wdata[2:0];
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_clr_wr; wr_ctl && i_wdata[0] && !i_wdata[7] ##1 !wr_ctl; endsequence
  sequence s_rel_wr; hold_q && wr_ctl && !i_wdata[7] ##1 !wr_ctl; endsequence
  sequence s_tick8;
    sel0_q == tpc_pkg::SEL_DIV8 && $past(sel0_q) == tpc_pkg::SEL_DIV8 && t0;
  endsequence
  property p_rsv; rd_ctl |=> o_rdata[6:2] == 5'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
  property p_clr_self; s_clr_wr |-> rs ##1 !rs; endproperty
  a_clr_self: assert property (p_clr_self) else $error("clear did not self clear");
  property p_hold; hold_q && rs && !wr_ctl |=> rs; endproperty
  a_hold: assert property (p_hold) else $error("clear dropped under hold");
  property p_release; s_rel_wr |=> !rs; endproperty
  a_release: assert property (p_release) else $error("clear kept after hold off");
  property p_div1;
    sel0_q == tpc_pkg::SEL_DIV1 && $past(sel0_q) == tpc_pkg::SEL_DIV1 |-> t0;
  endproperty
  a_div1: assert property (p_div1) else $error("undivided clock missing");
  property p_stop;
    sel1_q == tpc_pkg::SEL_STOP && $past(sel1_q) == tpc_pkg::SEL_STOP |-> !t1;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped timer got a pulse");
  property p_tap8; s_tick8 |-> (##1 !t0 [*7] ##1 t0) or (##[0:8] wr_cfg); endproperty
  a_tap8: assert property (p_tap8) else $error("divide by 8 period wrong");
  property p_clr_first; $fell(rs) && both8 |-> !(t0 || t1) [*8] ##1 (t0 && t1); endproperty
  a_clr_first: assert property (p_clr_first) else $error("tap restart wrong");
  property p_ext_rise;
    sel1_q == tpc_pkg::SEL_EXT_RISE && $rose(p1) |-> !t1 [*2] ##1 t1 ##1 !t1;
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("rising pin pulse wrong");
  property p_ext_fall;
    sel0_q == tpc_pkg::SEL_EXT_FALL && $changed(p0) |-> ##2 (t0 != $past(p0, 2));
  endproperty
  a_ext_fall: assert property (p_ext_fall) else $error("falling pin pulse wrong");
endmodule : tpc_top_asserts

//--- tb/tpc_pin_src.sv
// Model of the external clock source that drives both timer pins
`timescale 1ns/100ps
module tpc_pin_src (
  input  wire logic       i_sys_clk,  // Paces the edges only
  input  wire logic       i_run,      // Source stands still while low
  input  wire logic [3:0] i_half,     // Half period of pin 1, in cycles
  output logic            o_pin0,     // Pin 0, one cycle slower per half
  output logic            o_pin1      // Pin 1
);
  int n0 = 0;  // Cycles spent in the current half, pin 0
  int n1 = 0;  // Same for pin 1
  initial begin
    o_pin0 = 1'b1;
    o_pin1 = 1'b0;
  end
  // Edges land 3 ns into the high phase, where the sampling latch is open
  // Halves of two cycles or more keep the rate under the clock over 2.5
  always @(posedge i_sys_clk) begin
    if (i_run) begin
      n0++;
      n1++;
      if (n0 > i_half) begin
        n0 = 0;
        o_pin0 <= #3 ~o_pin0;
      end
      if (n1 >= i_half) begin
        n1 = 0;
        o_pin1 <= #3 ~o_pin1;
      end
    end
  end
endmodule : tpc_pin_src

//--- tb/tb.sv
// Self-checking bench for the timer clock block
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h exp %h", $time, (a), (e)); end end
module tb;
  logic       i_sys_clk = 1'b0;  // 40 MHz clock
  logic       i_sys_rst = 1'b1;  // Held for 16 cycles
  logic [7:0] i_addr    = 8'h00;
  logic [7:0] i_wdata   = 8'h00;
  logic       i_wr      = 1'b0;
  logic       i_rd      = 1'b0;
  logic       run       = 1'b0;  // Lets the pin source toggle
  logic [7:0] o_rdata;
  logic       pin0, pin1, t0, t1, rs, ars, v1;
  logic [7:0] x, y;
  int         c0, c1, e0, e1, d0, d1, g0, g1, k;
  int         n_mismatch  = 0;
  int         check_count = 0;
  int         cyc         = 0;
  tpc_top dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_timer0_ext_clock_pin(pin0), .i_timer1_ext_clock_pin(pin1),
    .o_timer0_count_clock(t0), .o_timer1_count_clock(t1),
    .o_shared_prescaler_reset(rs), .o_async_prescaler_reset(ars));
  tpc_pin_src u_src (.i_sys_clk(i_sys_clk), .i_run(run), .i_half(4'h2),
    .o_pin0(pin0), .o_pin1(pin1));
  always #12.5 i_sys_clk = ~i_sys_clk;
  // Bus write, then one idle cycle so the strobe is never raised twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
    @(posedge i_sys_clk);
  endtask : wr
  // Bus read, compared in the one cycle the data stands
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1 `CHK(o_rdata, e)
    @(posedge i_sys_clk);
  endtask : rdc
  // Counts pulses and pin edges at falling clock edges, where all is settled
  task automatic cnt(input int n, output int a, output int b, output int f, output int r);
    logic q0;
    logic q1;
    a = 0;
    b = 0;
    f = 0;
    r = 0;
    q0 = pin0;
    q1 = pin1;
    repeat (n) begin
      @(negedge i_sys_clk);
      a += int'(t0 === 1'b1);
      b += int'(t1 === 1'b1);
      f += int'(q0 && !pin0);
      r += int'(!q1 && pin1);
      q0 = pin0;
      q1 = pin1;
    end
    @(posedge i_sys_clk);
  endtask : cnt
  // Cycles until the next timer 0 pulse, bounded; also notes timer 1 then
  task automatic first(input int max, output int n, output logic o1);
    n = 0;
    do begin
      @(negedge i_sys_clk);
      n++;
      o1 = t1;
    end while (t0 !== 1'b1 && n < max);
    @(posedge i_sys_clk);
  endtask : first
  task automatic t_regs();
    rdc(tpc_pkg::OFS_GEN_SYNC, tpc_pkg::GEN_SYNC_RST);
    rdc(tpc_pkg::OFS_SEL_T0, 8'h00);
    rdc(8'h40, tpc_pkg::RDATA_NONE);
    wr(tpc_pkg::OFS_GEN_SYNC, 8'h7C);
    rdc(tpc_pkg::OFS_GEN_SYNC, 8'h00);
    wr(tpc_pkg::OFS_SEL_T1, 8'hFD);
    rdc(tpc_pkg::OFS_SEL_T1, 8'h05);
    wr(tpc_pkg::OFS_SEL_T1, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_div1();
    wr(tpc_pkg::OFS_SEL_T0, {5'h00, tpc_pkg::SEL_DIV1});
    cnt(16, c0, c1, e0, e1);
    `CHK(c0, 16)
    `CHK(c1, 0)
    wr(tpc_pkg::OFS_SEL_T0, 8'h00);
    $display("test div1 done");
  endtask : t_div1
  task automatic t_tap();
    logic [2:0] code [4];
    int         div  [4];
    code = '{tpc_pkg::SEL_DIV8, tpc_pkg::SEL_DIV64, tpc_pkg::SEL_DIV256, tpc_pkg::SEL_DIV1024};
    div  = '{8, 64, 256, 1024};
    // Clear first, so the phase read back is known to be zero
    wr(tpc_pkg::OFS_GEN_SYNC, 8'h01);
    rdc(tpc_pkg::OFS_PRESC_LO, 8'h00);
    i_rd   <= 1'b1;
    i_addr <= tpc_pkg::OFS_PRESC_LO;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 x = o_rdata;
    @(posedge i_sys_clk);
    wr(tpc_pkg::OFS_SEL_T1, {5'h00, tpc_pkg::SEL_DIV64});
    i_rd   <= 1'b1;
    i_addr <= tpc_pkg::OFS_PRESC_LO;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 y = o_rdata;
    @(posedge i_sys_clk);
    `CHK(8'(y - x), 8'h04)
    for (int i = 0; i < 4; i++) begin
      wr(tpc_pkg::OFS_SEL_T0, {5'h00, code[i]});
      first(div[i] + 2, k, v1);
      `CHK(k <= div[i], 1'b1)
      first(div[i] + 2, k, v1);
      `CHK(k, div[i])
      wr(tpc_pkg::OFS_SEL_T0, 8'h00);
    end
    $display("test taps done");
  endtask : t_tap
  task automatic t_clear();
    wr(tpc_pkg::OFS_SEL_T0, {5'h00, tpc_pkg::SEL_DIV8});
    wr(tpc_pkg::OFS_SEL_T1, {5'h00, tpc_pkg::SEL_DIV8});
    i_wr    <= 1'b1;
    i_addr  <= tpc_pkg::OFS_GEN_SYNC;
    i_wdata <= 8'h03;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    #1 `CHK({rs, ars}, 2'b11)
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 `CHK(o_rdata, 8'h03)
    `CHK(rs, 1'b0)
    @(posedge i_sys_clk);
    cnt(12, c0, c1, e0, e1);
    `CHK({c0, c1}, {32'd1, 32'd1})
    wr(tpc_pkg::OFS_GEN_SYNC, 8'h81);
    cnt(20, c0, c1, e0, e1);
    `CHK(c0 + c1, 0)
    rdc(tpc_pkg::OFS_GEN_SYNC, 8'h81);
    rdc(tpc_pkg::OFS_PRESC_LO, 8'h00);
    wr(tpc_pkg::OFS_GEN_SYNC, 8'h00);
    first(10, k, v1);
    `CHK(k, 8)
    `CHK(v1, 1'b1)
    $display("test clear done");
  endtask : t_clear
  task automatic t_ext();
    wr(tpc_pkg::OFS_SEL_T0, {5'h00, tpc_pkg::SEL_EXT_FALL}); // Pins still here
    wr(tpc_pkg::OFS_SEL_T1, {5'h00, tpc_pkg::SEL_EXT_RISE});
    run <= 1'b1;
    cnt(80, c0, c1, e0, e1);
    run <= 1'b0;
    cnt(6, d0, d1, g0, g1);
    `CHK(e0 > 10, 1'b1)
    `CHK(c0 + d0, e0 + g0)
    `CHK(c1 + d1, e1 + g1)
    $display("test pins done");
  endtask : t_ext
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  // Cuts a hang short; the full run needs about 2300 cycles
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_regs();
    t_div1();
    t_tap();
    t_clear();
    t_ext();
    end_of_test();
  end
endmodule : tb
bind tpc_top tpc_top_asserts u_chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_timer0_ext_clock_pin(i_timer0_ext_clock_pin),
  .i_timer1_ext_clock_pin(i_timer1_ext_clock_pin),
  .o_timer0_count_clock(o_timer0_count_clock), .o_timer1_count_clock(o_timer1_count_clock),
  .o_shared_prescaler_reset(o_shared_prescaler_reset),
  .o_async_prescaler_reset(o_async_prescaler_reset));
